// [rtl/mode_register_bank.sv]
// mode register bank for indices 06h..0ch: identity, test, calibration, termination, vref
// assumes commands arrive already decoded, one per cycle, on the core clock; the
// set point selects come from the neighbouring register on the same clock

`timescale 1ns/1ps

module mode_register_bank #(
  parameter logic [7:0] REVISION_ONE  = 8'h01,  // arbitrary value
  parameter logic [7:0] REVISION_TWO  = 8'h02,  // arbitrary value
  parameter logic [3:0] DENSITY_CODE  = mode_reg_pkg::DENSITY_16GB,
  parameter logic [1:0] IO_WIDTH_CODE = mode_reg_pkg::IO_WIDTH_X16
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        writeStrobe,
  input  wire logic        readStrobe,
  input  wire logic [5:0]  mode_register_index,
  input  wire logic [7:0]  mode_register_payload,
  input  wire logic        setpoint_access_select,
  input  wire logic        setpoint_active_select,
  input  wire logic        calPinGrounded,
  input  wire logic        calCommand,
  output logic      [15:0] readData,
  output logic             readValid,
  output logic      [7:0]  vendorTestMode,
  output logic             impedance_cal_default_restore,
  output logic             calibrationStart,
  output logic             calDefaultOnly,
  output logic      [2:0]  data_receiver_termination,
  output logic      [2:0]  command_receiver_termination,
  output logic      [5:0]  commandVrefSetting,
  output logic             command_vref_range_select
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (!(DENSITY_CODE <= mode_reg_pkg::DENSITY_16GB || DENSITY_CODE == mode_reg_pkg::DENSITY_1GB))
  begin : gDensityCheck
    $error("density code is reserved");
  end
  if (IO_WIDTH_CODE != mode_reg_pkg::IO_WIDTH_X16 && IO_WIDTH_CODE != mode_reg_pkg::IO_WIDTH_X8)
  begin : gWidthCheck
    $error("io width code is reserved");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]  testMode_reg,   testMode_next;
  logic [2:0]  dataTerm_reg    [2];
  logic [2:0]  dataTerm_next   [2];
  logic [2:0]  cmdTerm_reg     [2];
  logic [2:0]  cmdTerm_next    [2];
  logic [6:0]  vref_reg        [2];
  logic [6:0]  vref_next       [2];
  logic        calRestore_reg, calRestore_next;
  logic        calStart_reg,   calStart_next;
  logic        readValid_reg,  readValid_next;
  logic [15:0] readData_reg,   readData_next;
  logic [2:0]  actData_reg,    actData_next;
  logic [2:0]  actCmd_reg,     actCmd_next;
  logic [6:0]  actVref_reg,    actVref_next;
  logic        pinMeta_reg;
  logic        pinSync_reg;

  wire logic [7:0] geometryByte = {IO_WIDTH_CODE, DENSITY_CODE,
                                   mode_reg_pkg::SIXTEEN_PREFETCH_TYPE};

  function automatic logic hits(input logic [5:0] idx, input logic [5:0] target);
    hits = (idx == target);
  endfunction

  // ----------------------------------------------------------------
  // read multiplexer
  // ----------------------------------------------------------------
  // write-only registers read as zero; their contents stay internal
  function automatic logic [7:0] readByte(input logic [5:0] idx, input logic [6:0] vrefSel);
    readByte = mode_reg_pkg::ZERO_BYTE;
    if (hits(idx, mode_reg_pkg::REVISION_ID_ONE_IDX))
      readByte = REVISION_ONE;
    else if (hits(idx, mode_reg_pkg::REVISION_ID_TWO_IDX))
      readByte = REVISION_TWO;
    else if (hits(idx, mode_reg_pkg::DEVICE_GEOMETRY_INFO_IDX))
      readByte = geometryByte;
    else if (hits(idx, mode_reg_pkg::CMD_BUS_VREF_CTRL_IDX))
      readByte = {1'b0, vrefSel};
  endfunction

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    testMode_next   = testMode_reg;
    dataTerm_next   = dataTerm_reg;
    cmdTerm_next    = cmdTerm_reg;
    vref_next       = vref_reg;
    calRestore_next = 1'b0;
    // calibration runs only with the reference resistor fitted
    calStart_next   = calCommand && !pinSync_reg;
    readValid_next  = readStrobe;
    readData_next   = readData_reg;
    if (readStrobe)
      readData_next = {mode_reg_pkg::ZERO_BYTE,
                       readByte(mode_register_index, vref_reg[setpoint_access_select])};
    // read-only indices have no write path at all
    if (writeStrobe)
    begin
      if (hits(mode_register_index, mode_reg_pkg::VENDOR_TEST_CONTROL_IDX))
        testMode_next = mode_register_payload;
      if (hits(mode_register_index, mode_reg_pkg::IMPEDANCE_CAL_RESET_IDX))
        calRestore_next = mode_register_payload[mode_reg_pkg::CAL_RESTORE_BIT];
      if (hits(mode_register_index, mode_reg_pkg::RECEIVER_TERMINATION_CTRL_IDX))
      begin
        // reserved bits 3 and 7 are dropped here
        dataTerm_next[setpoint_access_select] =
          mode_register_payload[mode_reg_pkg::DATA_TERM_LSB +: 3];
        cmdTerm_next[setpoint_access_select] =
          mode_register_payload[mode_reg_pkg::CMD_TERM_LSB +: 3];
      end
      if (hits(mode_register_index, mode_reg_pkg::CMD_BUS_VREF_CTRL_IDX))
        vref_next[setpoint_access_select] = mode_register_payload[6:0];
    end
    // only the active copy steers the receivers
    actData_next = dataTerm_reg[setpoint_active_select];
    actCmd_next  = cmdTerm_reg[setpoint_active_select];
    actVref_next = vref_reg[setpoint_active_select];
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      testMode_reg   <= mode_reg_pkg::TEST_CONTROL_RESET;
      for (int i = 0; i < 2; i++)
      begin
        dataTerm_reg[i] <= mode_reg_pkg::TERM_DISABLED;
        cmdTerm_reg[i]  <= mode_reg_pkg::TERM_DISABLED;
        vref_reg[i]     <= {mode_reg_pkg::VREF_RANGE_RESET, mode_reg_pkg::VREF_SETTING_RESET};
      end
      calRestore_reg <= 1'b0;
      calStart_reg   <= 1'b0;
      readValid_reg  <= 1'b0;
      readData_reg   <= 16'h0000;
      actData_reg    <= mode_reg_pkg::TERM_DISABLED;
      actCmd_reg     <= mode_reg_pkg::TERM_DISABLED;
      actVref_reg    <= {mode_reg_pkg::VREF_RANGE_RESET, mode_reg_pkg::VREF_SETTING_RESET};
      // assume grounded until the strap has been sampled: default calibration is safe
      pinMeta_reg    <= 1'b1;
      pinSync_reg    <= 1'b1;
    end
    else
    begin
      testMode_reg   <= testMode_next;
      dataTerm_reg   <= dataTerm_next;
      cmdTerm_reg    <= cmdTerm_next;
      vref_reg       <= vref_next;
      calRestore_reg <= calRestore_next;
      calStart_reg   <= calStart_next;
      readValid_reg  <= readValid_next;
      readData_reg   <= readData_next;
      actData_reg    <= actData_next;
      actCmd_reg     <= actCmd_next;
      actVref_reg    <= actVref_next;
      pinMeta_reg    <= calPinGrounded;
      pinSync_reg    <= pinMeta_reg;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign readData                      = readData_reg;
  assign readValid                     = readValid_reg;
  assign vendorTestMode                = testMode_reg;
  assign impedance_cal_default_restore = calRestore_reg;
  assign calibrationStart              = calStart_reg;
  assign calDefaultOnly                = pinSync_reg;
  assign data_receiver_termination     = actData_reg;
  assign command_receiver_termination  = actCmd_reg;
  assign commandVrefSetting            = actVref_reg[mode_reg_pkg::VREF_SETTING_LSB +: 6];
  assign command_vref_range_select     = actVref_reg[mode_reg_pkg::VREF_RANGE_BIT];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_REV_ONE_READ: assert property (
    readStrobe && hits(mode_register_index, mode_reg_pkg::REVISION_ID_ONE_IDX)
    |=> readValid && readData == {8'h00, REVISION_ONE})
    else $error("first revision read wrong");

  AST_REV_TWO_READ: assert property (
    readStrobe && hits(mode_register_index, mode_reg_pkg::REVISION_ID_TWO_IDX)
    |=> readData == {8'h00, REVISION_TWO})
    else $error("second revision read wrong");

  AST_GEOMETRY_READ: assert property (
    readStrobe && hits(mode_register_index, mode_reg_pkg::DEVICE_GEOMETRY_INFO_IDX)
    |=> readData[1:0] == 2'h0 && readData[7:6] == IO_WIDTH_CODE
        && readData[5:2] == DENSITY_CODE)
    else $error("geometry read wrong");

  AST_TEST_WRITE: assert property (
    writeStrobe && hits(mode_register_index, mode_reg_pkg::VENDOR_TEST_CONTROL_IDX)
    |=> vendorTestMode == $past(mode_register_payload))
    else $error("test byte not stored");

  AST_CAL_RESTORE: assert property (
    impedance_cal_default_restore |-> $past(writeStrobe) && $past(mode_register_payload[0])
    && $past(mode_register_index) == mode_reg_pkg::IMPEDANCE_CAL_RESET_IDX)
    else $error("calibration restore without cause");

  AST_CAL_IGNORED: assert property (
    calDefaultOnly && calCommand |=> !calibrationStart)
    else $error("calibration started with grounded pin");

  AST_TERM_ACTIVE: assert property (
    writeStrobe && hits(mode_register_index, mode_reg_pkg::RECEIVER_TERMINATION_CTRL_IDX)
    && setpoint_access_select == setpoint_active_select
    ##1 $stable(setpoint_active_select) [*2]
    |-> data_receiver_termination == $past(mode_register_payload[2:0], 2)
        && command_receiver_termination == $past(mode_register_payload[6:4], 2))
    else $error("active termination not applied");

  AST_TERM_INACTIVE: assert property (
    writeStrobe && hits(mode_register_index, mode_reg_pkg::RECEIVER_TERMINATION_CTRL_IDX)
    && setpoint_access_select != setpoint_active_select && $stable(setpoint_active_select)
    ##1 $stable(setpoint_active_select)
    |=> $stable(data_receiver_termination))
    else $error("inactive copy disturbed operation");

  AST_VREF_READBACK: assert property (
    writeStrobe && hits(mode_register_index, mode_reg_pkg::CMD_BUS_VREF_CTRL_IDX)
    ##1 readStrobe && !writeStrobe && hits(mode_register_index, mode_reg_pkg::CMD_BUS_VREF_CTRL_IDX)
    && setpoint_access_select == $past(setpoint_access_select)
    |=> readData == {9'h000, $past(mode_register_payload[6:0], 2)})
    else $error("vref readback mismatch");

  AST_UPPER_ZERO: assert property (
    readValid |-> readData[15:8] == 8'h00)
    else $error("upper data lines not zero");

  AST_WO_READ_ZERO: assert property (
    readStrobe && hits(mode_register_index, mode_reg_pkg::RECEIVER_TERMINATION_CTRL_IDX)
    |=> readData == 16'h0000)
    else $error("write-only register leaked on read");

  AST_READ_PULSE: assert property (
    readStrobe |=> readValid)
    else $error("read not answered next cycle");

  AST_READ_NO_CAUSE: assert property (
    readValid |-> $past(readStrobe))
    else $error("read answer without read");

  AST_DENSITY_READ: assert property (
    readStrobe && hits(mode_register_index, mode_reg_pkg::DEVICE_GEOMETRY_INFO_IDX)
    |=> readData[5:2] == DENSITY_CODE)
    else $error("density code read wrong");

  // the test byte changes only through its own index
  AST_TEST_HOLD: assert property (
    !(writeStrobe && hits(mode_register_index, mode_reg_pkg::VENDOR_TEST_CONTROL_IDX))
    |=> $stable(vendorTestMode))
    else $error("test byte changed without write");

  AST_WO_TEST_READ_ZERO: assert property (
    readStrobe && (hits(mode_register_index, mode_reg_pkg::VENDOR_TEST_CONTROL_IDX)
    || hits(mode_register_index, mode_reg_pkg::IMPEDANCE_CAL_RESET_IDX))
    |=> readData == 16'h0000)
    else $error("test or calibration register leaked on read");

  AST_CAL_START_CAUSE: assert property (
    calibrationStart |-> $past(calCommand) && !$past(calDefaultOnly))
    else $error("calibration started without a permitted command");

  AST_VREF_ACTIVE: assert property (
    writeStrobe && hits(mode_register_index, mode_reg_pkg::CMD_BUS_VREF_CTRL_IDX)
    && setpoint_access_select == setpoint_active_select
    ##1 $stable(setpoint_active_select) [*2]
    |-> commandVrefSetting == $past(mode_register_payload[5:0], 2)
        && command_vref_range_select == $past(mode_register_payload[6], 2))
    else $error("active vref not applied");

  COV_TERM_WRITE: cover property (
    writeStrobe && hits(mode_register_index, mode_reg_pkg::RECEIVER_TERMINATION_CTRL_IDX));
  COV_SETPOINT_SWAP: cover property ($changed(setpoint_active_select));
  COV_CAL_START: cover property (calibrationStart);
  COV_VREF_READ: cover property (
    readStrobe && hits(mode_register_index, mode_reg_pkg::CMD_BUS_VREF_CTRL_IDX));

endmodule

// [rtl/mode_reg_pkg.sv]
// package of offsets, field positions and reset values for mode registers 06h..0ch
// assumes a single 250 MHz core clock shared by the command decoder and this bank
package mode_reg_pkg;

  // ----------------------------------------------------------------
  // mode register indices
  // ----------------------------------------------------------------
  localparam logic [5:0] REVISION_ID_ONE_IDX           = 6'h06;
  localparam logic [5:0] REVISION_ID_TWO_IDX           = 6'h07;
  localparam logic [5:0] DEVICE_GEOMETRY_INFO_IDX      = 6'h08;
  localparam logic [5:0] VENDOR_TEST_CONTROL_IDX       = 6'h09;
  localparam logic [5:0] IMPEDANCE_CAL_RESET_IDX       = 6'h0a;
  localparam logic [5:0] RECEIVER_TERMINATION_CTRL_IDX = 6'h0b;
  localparam logic [5:0] CMD_BUS_VREF_CTRL_IDX         = 6'h0c;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int TYPE_LSB          = 0;
  localparam int DENSITY_LSB       = 2;
  localparam int IO_WIDTH_LSB      = 6;
  localparam int CAL_RESTORE_BIT   = 0;
  localparam int DATA_TERM_LSB     = 0;
  localparam int CMD_TERM_LSB      = 4;
  localparam int VREF_SETTING_LSB  = 0;
  localparam int VREF_RANGE_BIT    = 6;

  // ----------------------------------------------------------------
  // codes and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] SIXTEEN_PREFETCH_TYPE = 2'h0;
  localparam logic [1:0] IO_WIDTH_X16          = 2'h0;
  localparam logic [1:0] IO_WIDTH_X8           = 2'h1;
  localparam logic [3:0] DENSITY_16GB          = 4'h6;
  localparam logic [3:0] DENSITY_1GB           = 4'hc;
  localparam logic [2:0] TERM_DISABLED         = 3'h0;
  localparam logic [2:0] TERM_RESERVED         = 3'h7;
  localparam logic [7:0] TEST_CONTROL_RESET    = 8'h00;
  localparam logic [5:0] VREF_SETTING_RESET    = 6'h00;
  localparam logic       VREF_RANGE_RESET      = 1'b1;
  localparam logic [7:0] ZERO_BYTE             = 8'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS    = 4000;
  localparam int READ_LATENCY_CYC = 1;

endpackage

// [verif/mode_ctrl_model.sv]
// controller-side model issuing mode register writes and reads, one command per task call except mrw_mrr, which issues a write then a read
// assumes the bank takes strobes on the rising edge of clk and answers a read one cycle later
`timescale 1ns/1ps
module mode_ctrl_model (
  input  wire logic        clk,
  input  wire logic [15:0] readData,
  input  wire logic        readValid,
  output logic             writeStrobe,
  output logic             readStrobe,
  output logic      [5:0]  mode_register_index,
  output logic      [7:0]  mode_register_payload
);
  initial
  begin
    writeStrobe = 1'b0;
    readStrobe = 1'b0;
    mode_register_index = 6'h3f;
    mode_register_payload = 8'ha5;
  end
  // idle lines show the inverse of the last command so a stale value never looks valid
  task automatic mrw(input logic [5:0] idx, input logic [7:0] data);
  begin
    @(negedge clk);
    writeStrobe = 1'b1;
    mode_register_index = idx;
    mode_register_payload = data;
    @(negedge clk);
    writeStrobe = 1'b0;
    mode_register_index = ~idx;
    mode_register_payload = ~data;
  end
  endtask
  task automatic mrr(input logic [5:0] idx, output logic [15:0] data, output bit late);
    int n;
  begin
    @(negedge clk);
    readStrobe = 1'b1;
    mode_register_index = idx;
    @(negedge clk);
    readStrobe = 1'b0;
    mode_register_index = ~idx;
    n = 0;
    late = 1'b1;
    data = 16'hdead;
    while (n < 4 && late)
    begin
      if (readValid === 1'b1)
      begin
        data = readData;
        late = 1'b0;
      end
      else
      begin
        @(negedge clk);
        n++;
      end
    end
  end
  endtask
  // write then read the same index on back-to-back edges
  task automatic mrw_mrr(input logic [5:0] idx, input logic [7:0] wdata,
                         output logic [15:0] data, output bit late);
    int n;
  begin
    @(negedge clk);
    writeStrobe = 1'b1;
    mode_register_index = idx;
    mode_register_payload = wdata;
    @(negedge clk);
    writeStrobe = 1'b0;
    readStrobe = 1'b1;
    mode_register_payload = ~wdata;
    @(negedge clk);
    readStrobe = 1'b0;
    mode_register_index = ~idx;
    n = 0;
    late = 1'b1;
    data = 16'hdead;
    while (n < 4 && late)
    begin
      if (readValid === 1'b1)
      begin
        data = readData;
        late = 1'b0;
      end
      else
      begin
        @(negedge clk);
        n++;
      end
    end
  end
  endtask
endmodule

// [verif/sdram_mode_register_bank_6_12_test.sv]
// self-checking bench for the mode register bank, random settings from a fixed seed
// assumes the design files are compiled first; inputs change on the falling edge
`timescale 1ns/1ps
module sdram_mode_register_bank_6_12_test;
  logic clk, rst, wS, rS, acc, act, calPinGrounded, calCommand, late;
  logic [5:0] idx;
  logic [7:0] pay, r;
  logic [15:0] rd, got;
  logic readValid, vrefRange, restore, calStart, calDefaultOnly;
  logic [7:0] vendorTestMode;
  logic [2:0] dTerm, cTerm;
  logic [5:0] vrefSet;
  logic [7:0] term [2];
  logic [6:0] vref [2];
  int n_fail, checked, seed, i, n;
  // ----------------------------------------------------------------
  // design and controller model
  // ----------------------------------------------------------------
  mode_ctrl_model u_ctrl (.clk(clk), .readData(rd), .readValid(readValid), .writeStrobe(wS),
    .readStrobe(rS), .mode_register_index(idx), .mode_register_payload(pay));
  mode_register_bank u_dut (.clk(clk), .rst(rst), .writeStrobe(wS), .readStrobe(rS),
    .mode_register_index(idx), .mode_register_payload(pay), .setpoint_access_select(acc),
    .setpoint_active_select(act), .calPinGrounded(calPinGrounded), .calCommand(calCommand),
    .readData(rd), .readValid(readValid), .vendorTestMode(vendorTestMode),
    .impedance_cal_default_restore(restore), .calibrationStart(calStart),
    .calDefaultOnly(calDefaultOnly), .data_receiver_termination(dTerm),
    .command_receiver_termination(cTerm), .commandVrefSetting(vrefSet),
    .command_vref_range_select(vrefRange));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
  begin
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  task automatic report_and_stop;
  begin
    $display("counts: checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
  begin
    u_ctrl.mrr(a, got, late);
    if (late)
    begin
      n_fail++;
      report_and_stop();
    end
    check(got, {8'h00, exp});
  end
  endtask
  // counts how many of the next three cycles a pulse output is high
  task automatic pulses(input int which, output int cnt);
  begin
    cnt = 0;
    repeat (3)
    begin
      cnt += (which == 0) ? (restore === 1'b1) : (calStart === 1'b1);
      @(negedge clk);
    end
  end
  endtask
  function automatic logic [7:0] geom();
    return {mode_reg_pkg::IO_WIDTH_X16, mode_reg_pkg::DENSITY_16GB,
            mode_reg_pkg::SIXTEEN_PREFETCH_TYPE};
  endfunction
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    n_fail = 0;
    checked = 0;
    seed = 15;
    rst = 1'b1;
    acc = 1'b0;
    act = 1'b0;
    calPinGrounded = 1'b1;
    calCommand = 1'b0;
    term = '{8'h00, 8'h00};
    vref = '{7'h40, 7'h40};
    repeat (5) @(negedge clk);
    rst = 1'b0;
    check(vendorTestMode, mode_reg_pkg::TEST_CONTROL_RESET);
    check({cTerm, dTerm}, 6'h00);
    check({vrefRange, vrefSet}, 7'h40);
    $display("test reset done");
    rd_chk(6'h06, 8'h01);
    rd_chk(6'h07, 8'h02);
    rd_chk(6'h08, geom());
    u_ctrl.mrw(6'h06, 8'hff);
    u_ctrl.mrw(6'h08, 8'hff);
    rd_chk(6'h06, 8'h01);
    rd_chk(6'h08, geom());
    rd_chk(6'h20, 8'h00);
    $display("test identity done");
    r = $random(seed);
    u_ctrl.mrw(6'h09, r);
    repeat (2) @(negedge clk);
    check(vendorTestMode, r);
    rd_chk(6'h09, 8'h00);
    u_ctrl.mrw(6'h0a, 8'hfe);
    pulses(0, n);
    check(n, 0);
    u_ctrl.mrw(6'h0a, 8'h01);
    pulses(0, n);
    check(n, 1);
    $display("test test-mode and restore done");
    for (i = 0; i < 2; i++)
    begin
      @(negedge clk);
      calCommand = 1'b1;
      @(negedge clk);
      calCommand = 1'b0;
      pulses(1, n);
      check(n, i);
      check(calDefaultOnly, i == 0);
      calPinGrounded = 1'b0;
      repeat (4) @(negedge clk);
    end
    $display("test calibration strap done");
    for (i = 0; i < 12; i++)
    begin
      @(negedge clk);
      acc = $random(seed);
      act = $random(seed);
      r = (i == 0) ? 8'hff : $random(seed);
      u_ctrl.mrw(6'h0b, r);
      term[acc] = r & 8'h77;
      r = (i == 1) ? 8'hff : $random(seed);
      u_ctrl.mrw(6'h0c, r);
      vref[acc] = r[6:0];
      rd_chk(6'h0b, 8'h00);
      rd_chk(6'h0c, {1'b0, vref[acc]});
      repeat (3) @(negedge clk);
      check(dTerm, term[act][2:0]);
      check(cTerm, term[act][6:4]);
      check({vrefRange, vrefSet}, vref[act]);
    end
    r = $random(seed);
    u_ctrl.mrw_mrr(6'h0c, r, got, late);
    if (late)
    begin
      n_fail++;
      report_and_stop();
    end
    check(got, {9'h000, r[6:0]});
    $display("test set points done");
    report_and_stop();
  end
endmodule
